//--- logic/pcrs_top.sv
/*
 * Clock rate select: two select registers on the special-function bus,
 * the divide-by-two core clock enable, glitch-free double-speed switch,
 * and per-peripheral cycle strobes.
 * Assumes clk is the oscillator input and the bus runs on that clock.
 */
`timescale 1ns/1ps
`include "pcrs_regs.svh"

// Operation
// RL1: peripheral_clock_select at 8Fh holds can, watchdog, counter array, uart, timer 2/1/0 and cpu_double_speed bits.
// RL2: serial_port_clock_select at 9Fh holds spi_rate_sel in bit 0 with bits 7-1 reserved.
// RL3: a select bit cleared gives 6 oscillator periods per peripheral cycle and set gives 12.
// RL4: the uart select bit acts only in uart modes 0 and 2.
// RL5: select bits take effect only while cpu_double_speed is set, else peripherals run at standard rate.
// RL6: reserved bits of serial_port_clock_select read back as zero here.
// RL7: software keeps the reserved bits of serial_port_clock_select at zero.
// RL8: both select registers reset to zero, so the cpu starts in standard mode.
// RL9: cpu_double_speed cleared gives 12 oscillator clocks per machine cycle and set gives 6.
// RL10: standard mode divides the oscillator by two for the core, double speed bypasses it.
// RL11: a change of cpu_double_speed is applied only on a rising edge of the divided clock.
// RL12: a lane runs at 12 clocks when double speed is off or its select bit is set, else at 6.
module pcrs_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire pcrs_pkg::pcrs_byte_t sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire pcrs_pkg::pcrs_byte_t sfr_wdata,
    output pcrs_pkg::pcrs_byte_t sfr_rdata_q,
    input wire pcrs_pkg::pcrs_uart_mode_t uart_mode,
    output logic core_tick_q,
    output logic double_active_q,
    output pcrs_pkg::pcrs_lanes_t tick_q
);
    import pcrs_pkg::*;

    pcrs_byte_t periph_sel_q;
    pcrs_byte_t periph_sel_d;
    pcrs_byte_t serial_sel_q;
    pcrs_byte_t serial_sel_d;
    pcrs_byte_t rdata_d;
    logic hit_periph;
    logic hit_serial;
    logic div_q;
    logic div_rise;
    logic double_d;
    logic core_tick_d;
    logic uart_follows;
    pcrs_lanes_t sel_bits;
    pcrs_lanes_t slow;

    // register decode
    assign hit_periph = (sfr_addr == `PCRS_PERIPH_SEL_ADDR);
    assign hit_serial = (sfr_addr == `PCRS_SERIAL_SEL_ADDR);

    // RL1: select register write
    assign periph_sel_d = (sfr_wr && hit_periph) ? sfr_wdata : periph_sel_q;
    // RL2: only bit 0 is stored
    assign serial_sel_d = (sfr_wr && hit_serial) ? (sfr_wdata & `PCRS_SERIAL_MASK) : serial_sel_q;

    // RL6: reserved bits return zero
    assign rdata_d = !sfr_rd ? sfr_rdata_q :
                     hit_periph ? periph_sel_q :
                     hit_serial ? (serial_sel_q & `PCRS_SERIAL_MASK) : '0;

    // RL11: apply on divided clock rising edge
    assign div_rise = !div_q;
    assign double_d = div_rise ? periph_sel_q[`PCRS_BIT_DOUBLE] : double_active_q;

    // RL10: divider bypassed in double speed
    assign core_tick_d = double_d ? 1'b1 : div_rise;

    // RL4: uart select only in modes 0 and 2
    assign uart_follows = (uart_mode == `PCRS_UART_MODE0) || (uart_mode == `PCRS_UART_MODE2);

    assign sel_bits[PCRS_LANE_CPU] = 1'b0;
    assign sel_bits[PCRS_LANE_T0] = periph_sel_q[`PCRS_BIT_T0];
    assign sel_bits[PCRS_LANE_T1] = periph_sel_q[`PCRS_BIT_T1];
    assign sel_bits[PCRS_LANE_T2] = periph_sel_q[`PCRS_BIT_T2];
    assign sel_bits[PCRS_LANE_UART] = periph_sel_q[`PCRS_BIT_UART] || !uart_follows;
    assign sel_bits[PCRS_LANE_CNTARR] = periph_sel_q[`PCRS_BIT_CNTARR];
    assign sel_bits[PCRS_LANE_WDOG] = periph_sel_q[`PCRS_BIT_WDOG];
    assign sel_bits[PCRS_LANE_CAN] = periph_sel_q[`PCRS_BIT_CAN];
    assign sel_bits[PCRS_LANE_SPI] = serial_sel_q[`PCRS_BIT_SPI];

    // RL5: select bits gated by double speed
    // RL12: slow when double off or bit set
    // RL9: cpu lane follows double speed alone
    assign slow = {`PCRS_LANES{!double_active_q}} | sel_bits;

    // RL8: zero after reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            periph_sel_q <= `PCRS_PERIPH_SEL_RST;
            serial_sel_q <= `PCRS_SERIAL_SEL_RST;
            sfr_rdata_q <= '0;
        end else begin
            periph_sel_q <= periph_sel_d;
            serial_sel_q <= serial_sel_d;
            sfr_rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 1'b0;
            double_active_q <= 1'b0;
            core_tick_q <= 1'b0;
        end else begin
            div_q <= !div_q;
            double_active_q <= double_d;
            core_tick_q <= core_tick_d;
        end
    end

    pcrs_strobe_gen u_strobe (
        .clk(clk),
        .arst_n(arst_n),
        .slow(slow),
        .tick_q(tick_q)
    );

    // cycles since each lane's last strobe, read only by checks
    logic [`PCRS_PH_W-1:0] gap_q [`PCRS_LANES];
    for (genvar g = 0; g < `PCRS_LANES; g++) begin : g_gap
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                gap_q[g] <= `PCRS_GAP_MAX;
            end else if (tick_q[g]) begin
                gap_q[g] <= '0;
            end else if (gap_q[g] != `PCRS_GAP_MAX) begin
                gap_q[g] <= gap_q[g] + `PCRS_PH_W'(1);
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_slow_steady;
        !double_active_q [*8] ##1 !double_active_q [*5];
    endsequence

    sequence s_t0_fast_steady;
        (double_active_q && !periph_sel_q[`PCRS_BIT_T0]) [*8]
            ##1 (double_active_q && !periph_sel_q[`PCRS_BIT_T0]) [*4];
    endsequence

    // uart held in a mode that ignores its select bit
    sequence s_uart_fixed;
        (!uart_follows) [*8];
    endsequence

    sequence s_uart_fast;
        (double_active_q && uart_follows && !periph_sel_q[`PCRS_BIT_UART]) [*8];
    endsequence

    periph_write_a: assert property ( // RL1
        sfr_wr && hit_periph |=> periph_sel_q == $past(sfr_wdata))
        else $error("peripheral select write not stored");

    periph_read_a: assert property ( // RL1
        sfr_rd && hit_periph |=> sfr_rdata_q == $past(periph_sel_q))
        else $error("peripheral select readback wrong");

    unmapped_read_a: assert property ( // RL1
        sfr_rd && !hit_periph && !hit_serial |=> sfr_rdata_q == '0)
        else $error("unmapped read not zero");

    serial_write_a: assert property ( // RL2
        sfr_wr && hit_serial |=> serial_sel_q == ($past(sfr_wdata) & `PCRS_SERIAL_MASK))
        else $error("serial select write not masked");

    serial_mask_a: assert property ( // RL2
        sfr_rd && hit_serial |=> (sfr_rdata_q & ~`PCRS_SERIAL_MASK) == '0
            && sfr_rdata_q[`PCRS_BIT_SPI] == $past(serial_sel_q[`PCRS_BIT_SPI]))
        else $error("serial select readback wrong");

    t0_fast_gap_a: assert property ( // RL3
        s_t0_fast_steady ##1 tick_q[PCRS_LANE_T0] && gap_q[PCRS_LANE_T0] != `PCRS_GAP_MAX
            |-> gap_q[PCRS_LANE_T0] == `PCRS_GAP_FAST)
        else $error("fast timer 0 strobe spacing not 6");

    spi_fast_gap_a: assert property ( // RL3
        (double_active_q && !serial_sel_q[`PCRS_BIT_SPI]) [*8]
            ##0 tick_q[PCRS_LANE_SPI] && gap_q[PCRS_LANE_SPI] != `PCRS_GAP_MAX
            |-> gap_q[PCRS_LANE_SPI] == `PCRS_GAP_FAST)
        else $error("fast spi strobe spacing not 6");

    uart_mode_a: assert property ( // RL4
        s_uart_fixed ##0 tick_q[PCRS_LANE_UART] && gap_q[PCRS_LANE_UART] != `PCRS_GAP_MAX
            |-> gap_q[PCRS_LANE_UART] == `PCRS_GAP_SLOW)
        else $error("uart strobe fast outside modes 0 and 2");

    uart_fast_a: assert property ( // RL4
        s_uart_fast ##0 tick_q[PCRS_LANE_UART] && gap_q[PCRS_LANE_UART] != `PCRS_GAP_MAX
            |-> gap_q[PCRS_LANE_UART] == `PCRS_GAP_FAST)
        else $error("uart strobe not fast in modes 0 and 2");

    std_gate_a: assert property ( // RL5
        s_slow_steady ##1 tick_q[PCRS_LANE_SPI] && gap_q[PCRS_LANE_SPI] != `PCRS_GAP_MAX
            |-> gap_q[PCRS_LANE_SPI] == `PCRS_GAP_SLOW)
        else $error("select bit acted in standard mode");

    cpu_fast_gap_a: assert property ( // RL9
        double_active_q [*8] ##0 tick_q[PCRS_LANE_CPU] && gap_q[PCRS_LANE_CPU] != `PCRS_GAP_MAX
            |-> gap_q[PCRS_LANE_CPU] == `PCRS_GAP_FAST)
        else $error("machine cycle not 6 clocks in double speed");

    core_div_a: assert property ( // RL10
        !double_active_q && core_tick_q && $past(!double_active_q) |=> !core_tick_q || double_active_q)
        else $error("core tick not divided by two");

    core_every_a: assert property ( // RL10
        double_active_q |-> core_tick_q)
        else $error("core tick divided in double speed");

    double_sync_a: assert property ( // RL11
        double_active_q != $past(double_active_q)
            |-> div_q && double_active_q == $past(periph_sel_q[`PCRS_BIT_DOUBLE]))
        else $error("double speed switched off divided edge");

    lane_rate_a: assert property ( // RL12
        s_slow_steady ##1 tick_q[PCRS_LANE_CAN] && gap_q[PCRS_LANE_CAN] != `PCRS_GAP_MAX
            |-> gap_q[PCRS_LANE_CAN] == `PCRS_GAP_SLOW)
        else $error("can lane not at 12 clocks in standard mode");
endmodule

//--- shared/pcrs_regs.svh
/*
 * Addresses, bit positions, reset values and cycle counts for the
 * peripheral clock rate select block.
 * Assumes an 8-bit special-function register bus with 8-bit addresses.
 */
`ifndef PCRS_REGS_SVH
`define PCRS_REGS_SVH

// special-function addresses
`define PCRS_PERIPH_SEL_ADDR 8'h8F
`define PCRS_SERIAL_SEL_ADDR 8'h9F

// reset values
`define PCRS_PERIPH_SEL_RST 8'h00
`define PCRS_SERIAL_SEL_RST 8'h00

// peripheral_clock_select fields
`define PCRS_BIT_CAN 7
`define PCRS_BIT_WDOG 6
`define PCRS_BIT_CNTARR 5
`define PCRS_BIT_UART 4
`define PCRS_BIT_T2 3
`define PCRS_BIT_T1 2
`define PCRS_BIT_T0 1
`define PCRS_BIT_DOUBLE 0

// serial_port_clock_select fields
`define PCRS_BIT_SPI 0
`define PCRS_SERIAL_MASK 8'h01

// oscillator periods per cycle, and phase counter end points
`define PCRS_SLOW_CLKS 12
`define PCRS_FAST_CLKS 6
`define PCRS_PH_W 4
`define PCRS_PH_LAST 4'hB
`define PCRS_PH_HALF 4'h5

// uart modes that follow the rate select
`define PCRS_UART_MODE0 2'h0
`define PCRS_UART_MODE2 2'h2

// lane count and gap figures seen by the checks
`define PCRS_LANES 9
`define PCRS_GAP_FAST 4'h5
`define PCRS_GAP_SLOW 4'hB
`define PCRS_GAP_MAX 4'hF

`endif

//--- shared/pcrs_pkg.sv
/*
 * Types shared by the clock rate select files.
 * Assumes pcrs_regs.svh supplies the numeric constants.
 */
package pcrs_pkg;
    typedef logic [7:0] pcrs_byte_t;
    typedef logic [1:0] pcrs_uart_mode_t;
    typedef logic [8:0] pcrs_lanes_t;

    // strobe lane numbering
    typedef enum logic [3:0] {
        PCRS_LANE_CPU = 4'h0,
        PCRS_LANE_T0 = 4'h1,
        PCRS_LANE_T1 = 4'h2,
        PCRS_LANE_T2 = 4'h3,
        PCRS_LANE_UART = 4'h4,
        PCRS_LANE_CNTARR = 4'h5,
        PCRS_LANE_WDOG = 4'h6,
        PCRS_LANE_CAN = 4'h7,
        PCRS_LANE_SPI = 4'h8
    } pcrs_lane_t;
endpackage

//--- logic/pcrs_strobe_gen.sv
/*
 * Phase counter over twelve oscillator periods and one registered
 * cycle strobe per lane, every 6 or 12 periods as each slow bit asks.
 * Assumes slow bits come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "pcrs_regs.svh"

module pcrs_strobe_gen (
    input wire logic clk,
    input wire logic arst_n,
    input wire pcrs_pkg::pcrs_lanes_t slow,
    output pcrs_pkg::pcrs_lanes_t tick_q
);
    import pcrs_pkg::*;

    logic [`PCRS_PH_W-1:0] phase_q;
    logic [`PCRS_PH_W-1:0] phase_d;
    logic at_last;
    logic at_half;
    pcrs_lanes_t tick_d;

    assign at_last = (phase_q == `PCRS_PH_LAST);
    assign at_half = (phase_q == `PCRS_PH_HALF);
    assign phase_d = at_last ? '0 : phase_q + `PCRS_PH_W'(1);

    // RL3: 6 or 12 periods
    assign tick_d = {`PCRS_LANES{at_last}} | ({`PCRS_LANES{at_half}} & ~slow);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= '0;
            tick_q <= '0;
        end else begin
            phase_q <= phase_d;
            tick_q <= tick_d;
        end
    end
endmodule

//--- tb/pcrs_uart_model.sv
/*
 * UART stand-in: holds the uart mode seen by the block.
 * Assumes mode requests arrive on rising clk.
 */
`timescale 1ns/1ps

module pcrs_uart_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire pcrs_pkg::pcrs_uart_mode_t mode_req,
    output pcrs_pkg::pcrs_uart_mode_t uart_mode_q
);
    import pcrs_pkg::*;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            uart_mode_q <= 2'h0;
        end else begin
            uart_mode_q <= mode_req;
        end
    end
endmodule

//--- tb/pcrs_testbench.sv
/*
 * Self-checking bench for pcrs_top: select registers, strobe spacing.
 * Assumes the hand-over timing of the bus and the strobes.
 */
`timescale 1ns/1ps
`include "pcrs_regs.svh"

module testbench;
    import pcrs_pkg::*;
    logic clk;
    logic arst_n;
    pcrs_byte_t sfr_addr;
    logic sfr_wr;
    logic sfr_rd;
    pcrs_byte_t sfr_wdata;
    pcrs_byte_t sfr_rdata_q;
    pcrs_uart_mode_t mode_req;
    pcrs_uart_mode_t uart_mode;
    logic core_tick_q;
    logic double_active_q;
    pcrs_lanes_t tick_q;
    int failures;
    int checks_done;
    int cycles;

    pcrs_top u_pcrs_top (.clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata_q, .uart_mode, .core_tick_q, .double_active_q, .tick_q);
    pcrs_uart_model u_pcrs_uart_model (.clk, .arst_n, .mode_req,
        .uart_mode_q(uart_mode));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic close_out();
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            close_out();
        end
    end

    task automatic cmp_byte(string what, pcrs_byte_t exp, pcrs_byte_t got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_num(string what, int exp, int got);
        checks_done++;
        if (got != exp) begin
            failures++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask

    task automatic wr(pcrs_byte_t a, pcrs_byte_t d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask

    task automatic rd(pcrs_byte_t a, output pcrs_byte_t d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(negedge clk);
        d = sfr_rdata_q;
    endtask

    // spacing of the 2nd and 3rd strobe on one lane
    task automatic gap_is(int lane, int exp);
        int t;
        int last;
        int seen;
        int gap;
        t = 0;
        last = 0;
        seen = 0;
        gap = 0;
        while (seen < 3 && t < 60) begin
            @(negedge clk);
            t++;
            if (tick_q[lane] === 1'b1) begin
                seen++;
                gap = t - last;
                last = t;
            end
        end
        cmp_num($sformatf("gap lane %0d", lane), exp, (seen == 3) ? gap : 0);
    endtask

    task automatic core_is(int exp);
        int n;
        n = 0;
        repeat (12) begin
            @(negedge clk);
            if (core_tick_q === 1'b1) n++;
        end
        cmp_num("core ticks", exp, n);
    endtask

    task automatic t_reset();
        pcrs_byte_t d;
        rd(`PCRS_PERIPH_SEL_ADDR, d);
        cmp_byte("periph reset", `PCRS_PERIPH_SEL_RST, d);
        rd(`PCRS_SERIAL_SEL_ADDR, d);
        cmp_byte("serial reset", `PCRS_SERIAL_SEL_RST, d);
        core_is(6);
        for (int i = 0; i < 9; i++) gap_is(i, 12);
    endtask

    task automatic t_fast();
        wr(`PCRS_PERIPH_SEL_ADDR, 8'h01);
        repeat (3) @(negedge clk);
        cmp_byte("double active", 8'h01, {7'h00, double_active_q});
        core_is(12);
        for (int i = 0; i < 9; i++) gap_is(i, 6);
    endtask

    task automatic t_slow();
        pcrs_byte_t d;
        for (int i = 1; i < 8; i++) begin
            wr(`PCRS_PERIPH_SEL_ADDR, 8'h01 | (8'h01 << i));
            rd(`PCRS_PERIPH_SEL_ADDR, d);
            cmp_byte("periph sel", 8'h01 | (8'h01 << i), d);
            gap_is(i, 12);
            gap_is(0, 6);
        end
        wr(`PCRS_PERIPH_SEL_ADDR, 8'h01);
        wr(`PCRS_SERIAL_SEL_ADDR, 8'h01);
        rd(`PCRS_SERIAL_SEL_ADDR, d);
        cmp_byte("serial sel", 8'h01, d);
        gap_is(8, 12);
        wr(`PCRS_SERIAL_SEL_ADDR, 8'h00);
        gap_is(8, 6);
    endtask

    task automatic t_uart();
        wr(`PCRS_PERIPH_SEL_ADDR, 8'h11);
        gap_is(4, 12);
        wr(`PCRS_PERIPH_SEL_ADDR, 8'h01);
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            mode_req <= m[1:0];
            gap_is(4, (m == 1 || m == 3) ? 12 : 6);
        end
        @(posedge clk);
        mode_req <= 2'h0;
    endtask

    task automatic t_unmapped();
        pcrs_byte_t d;
        wr(8'h8E, 8'hFF);
        rd(8'h8E, d);
        cmp_byte("unmapped", 8'h00, d);
        rd(`PCRS_PERIPH_SEL_ADDR, d);
        cmp_byte("periph kept", 8'h01, d);
        wr(`PCRS_PERIPH_SEL_ADDR, 8'hFE);
        repeat (3) @(negedge clk);
        core_is(6);
        gap_is(1, 12);
    endtask

    initial begin
        arst_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        mode_req = 2'h0;
        failures = 0;
        checks_done = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_fast();
        t_slow();
        t_uart();
        t_unmapped();
        close_out();
    end
endmodule
